// [hdl/req_filter_pkg.sv]
package req_filter_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_ASYNC_HI_SET = 8'h00;
  localparam logic [7:0] OFF_ASYNC_HI_CLR = 8'h04;
  localparam logic [7:0] OFF_ASYNC_LO_SET = 8'h08;
  localparam logic [7:0] OFF_ASYNC_LO_CLR = 8'h0C;
  localparam logic [7:0] OFF_PHYS_HI_SET = 8'h10;
  localparam logic [7:0] OFF_PHYS_HI_CLR = 8'h14;
  localparam logic [7:0] OFF_PHYS_LO_SET = 8'h18;
  localparam logic [7:0] OFF_PHYS_LO_CLR = 8'h1C;
  localparam logic [7:0] OFF_PHYS_LIMIT = 8'h20;
  localparam logic [7:0] OFF_CTRL = 8'h24;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int ACCEPT_ALL_BIT = 31;
  localparam int CTRL_RRQ_EN_BIT = 0;
  localparam logic [31:0] FILTER_RESET = 32'h0000_0000;
  localparam logic [31:0] LIMIT_RESET = 32'h0000_0000;
  localparam logic [31:0] LIMIT_MAX = 32'hFFFF_0000;
  localparam logic [31:0] LIMIT_UNIMPL = 32'h0000_0000;
  localparam logic [47:0] LIMIT_FIXED = 48'h0001_0000_0000;
  localparam logic [15:0] LIMIT_LOW_ZERO = 16'h0000;
  localparam logic [9:0] LOCAL_BUS = 10'h3FF;
  localparam logic [47:0] ROM_BASE = 48'hFFFF_F000_0400;
  localparam logic [47:0] ROM_SIZE = 48'h0000_0000_0400;
  localparam logic [47:0] IRM_BASE = 48'hFFFF_F000_021C;
  localparam logic [47:0] IRM_SIZE = 48'h0000_0000_0010;

  // Where an accepted request is steered
  typedef enum logic [1:0] {
    DEST_DROP,
    DEST_PHYS,
    DEST_RRQ
  } dest_t;

endpackage : req_filter_pkg

// [hdl/async_request_filter_router.sv]
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/100ps

// Contract
// - Requests outside first 1K config ROM index the async filter by source
// - Async filter bit zero: request ignored, no acknowledge at all
// - Accepted offsets at or above limit go to receive request queue
// - Queue-bound request dropped when the receive request queue is disabled
// - Node accept bit admits node n on local alias or current bus
// - Accept-all bit admits every source, including remote buses
// - Bus reset clears async node bits, keeps accept-all; hard reset clears
// - Write one at set address sets bit, at clear address clears it
// - Reading set or clear address returns present filter contents
// - Below limit, phys filter bit one to physical unit, zero to queue
// - Phys node bit admits node n on local alias or current bus
// - Phys remote-bus bit admits nodes on any other bus number
// - Phys-refused requests go to queue if enabled, else ignored
// - Bus reset clears every phys filter bit including remote-bus bit
// - Physical range runs from zero up to, not including, the limit
// - Limit holds top 32 bits of 48-bit offset, low 16 zero
// - Unimplemented limit reads zero, read-only, range ends at 4 GB
// - Config ROM quadlet reads and resource registers bypass filters; code bypasses first 1K of ROM for any request type
module async_request_filter_router #(
  parameter bit LIMIT_IMPL = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bus_reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic req_valid,
  input wire logic [15:0] req_source_id,
  input wire logic [47:0] req_offset,
  input wire logic req_quadlet_read,
  input wire logic [9:0] local_bus_id,
  output logic resp_valid,
  output logic resp_ack,
  output req_filter_pkg::dest_t resp_dest
);
  import req_filter_pkg::*;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Pick the filter bit of one node across a 64-bit pair
  function automatic logic node_bit(input logic [31:0] hi,
                                    input logic [31:0] lo,
                                    input logic [5:0] node);
    logic [63:0] both;
    both = {hi, lo};
    node_bit = (node == 6'h3F) ? 1'b0 : both[node];
  endfunction : node_bit

  // Inside a window of [base, base+size)
  function automatic logic in_window(input logic [47:0] off,
                                     input logic [47:0] base,
                                     input logic [47:0] size);
    in_window = (off >= base) && (off < base + size);
  endfunction : in_window

  // Set/clear update of one filter word
  function automatic logic [31:0] set_clr(input logic [31:0] cur,
                                          input logic [31:0] wdata,
                                          input logic set_hit,
                                          input logic clr_hit);
    logic [31:0] v;
    v = cur;
    if (set_hit) begin
      v = v | wdata;
    end
    if (clr_hit) begin
      v = v & ~wdata;
    end
    set_clr = v;
  endfunction : set_clr

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] async_hi_r;
  logic [31:0] async_lo_r;
  logic [31:0] phys_hi_r;
  logic [31:0] phys_lo_r;
  logic [31:0] limit_r;
  logic rrq_enable_r;
  logic [31:0] async_hi_nxt;
  logic [31:0] async_lo_nxt;
  logic [31:0] phys_hi_nxt;
  logic [31:0] phys_lo_nxt;
  logic [31:0] limit_nxt;
  logic rrq_enable_nxt;
  logic [31:0] rdata_nxt;

  // Address decode
  wire hit_ahs = reg_wr && (reg_addr == OFF_ASYNC_HI_SET);
  wire hit_ahc = reg_wr && (reg_addr == OFF_ASYNC_HI_CLR);
  wire hit_als = reg_wr && (reg_addr == OFF_ASYNC_LO_SET);
  wire hit_alc = reg_wr && (reg_addr == OFF_ASYNC_LO_CLR);
  wire hit_phs = reg_wr && (reg_addr == OFF_PHYS_HI_SET);
  wire hit_phc = reg_wr && (reg_addr == OFF_PHYS_HI_CLR);
  wire hit_pls = reg_wr && (reg_addr == OFF_PHYS_LO_SET);
  wire hit_plc = reg_wr && (reg_addr == OFF_PHYS_LO_CLR);
  wire hit_lim = reg_wr && (reg_addr == OFF_PHYS_LIMIT);
  wire hit_ctl = reg_wr && (reg_addr == OFF_CTRL);

  // Software writes take effect, then bus reset wipes node bits on top
  wire [31:0] ahi_sw = set_clr(async_hi_r, reg_wdata, hit_ahs, hit_ahc);
  wire [31:0] alo_sw = set_clr(async_lo_r, reg_wdata, hit_als, hit_alc);
  wire [31:0] phi_sw = set_clr(phys_hi_r, reg_wdata, hit_phs, hit_phc);
  wire [31:0] plo_sw = set_clr(phys_lo_r, reg_wdata, hit_pls, hit_plc);
  wire [31:0] keep_all = 32'h1 << ACCEPT_ALL_BIT;

  // Bus reset keeps only the accept-all flag of the async filter
  assign async_hi_nxt = bus_reset ? (ahi_sw & keep_all) : ahi_sw;
  assign async_lo_nxt = bus_reset ? FILTER_RESET : alo_sw;
  assign phys_hi_nxt = bus_reset ? FILTER_RESET : phi_sw;
  assign phys_lo_nxt = bus_reset ? FILTER_RESET : plo_sw;
  // Limit is read-only zero when the option is left out
  assign limit_nxt = !LIMIT_IMPL ? LIMIT_UNIMPL :
                     (hit_lim ? reg_wdata : limit_r);
  assign rrq_enable_nxt = hit_ctl ? reg_wdata[CTRL_RRQ_EN_BIT] : rrq_enable_r;

  // Read mux: set and clear addresses show the same contents
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (reg_addr)
      OFF_ASYNC_HI_SET, OFF_ASYNC_HI_CLR: rdata_nxt = async_hi_r;
      OFF_ASYNC_LO_SET, OFF_ASYNC_LO_CLR: rdata_nxt = async_lo_r;
      OFF_PHYS_HI_SET, OFF_PHYS_HI_CLR: rdata_nxt = phys_hi_r;
      OFF_PHYS_LO_SET, OFF_PHYS_LO_CLR: rdata_nxt = phys_lo_r;
      OFF_PHYS_LIMIT: rdata_nxt = limit_r;
      OFF_CTRL: rdata_nxt = {31'h0, rrq_enable_r};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Register storage; limit resets to a plain zero since it is undefined
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      async_hi_r <= FILTER_RESET;
      async_lo_r <= FILTER_RESET;
      phys_hi_r <= FILTER_RESET;
      phys_lo_r <= FILTER_RESET;
      limit_r <= LIMIT_RESET;
      rrq_enable_r <= 1'b0;
      reg_rdata <= 32'h0000_0000;
    end else begin
      async_hi_r <= async_hi_nxt;
      async_lo_r <= async_lo_nxt;
      phys_hi_r <= phys_hi_nxt;
      phys_lo_r <= phys_lo_nxt;
      limit_r <= limit_nxt;
      rrq_enable_r <= rrq_enable_nxt;
      reg_rdata <= reg_rd ? rdata_nxt : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Request screening
  // ----------------------------------------------------------------
  wire [9:0] src_bus = req_source_id[15:6];
  wire [5:0] src_node = req_source_id[5:0];
  wire bus_local = (src_bus == LOCAL_BUS) || (src_bus == local_bus_id);

  // Unfiltered areas: first 1K of ROM (any request type) and resource regs; req_quadlet_read is not used
  wire in_rom = in_window(req_offset, ROM_BASE, ROM_SIZE);
  wire bypass = in_rom || in_window(req_offset, IRM_BASE, IRM_SIZE);

  // Async accept: node bit on a local bus, or accept-all
  wire async_all = async_hi_r[ACCEPT_ALL_BIT];
  wire async_node = bus_local &&
                    node_bit(async_hi_r, async_lo_r, src_node);
  wire async_ok = bypass || async_all || async_node;

  // Physical range end: limit with zero low half, or fixed 4 GB
  wire [47:0] range_end = LIMIT_IMPL ? {limit_r, LIMIT_LOW_ZERO}
                                     : LIMIT_FIXED;
  wire in_phys = req_offset < range_end;

  // Physical accept: node bit locally, remote-bus bit otherwise
  wire phys_node = bus_local &&
                   node_bit(phys_hi_r, phys_lo_r, src_node);
  wire phys_remote = !bus_local && phys_hi_r[ACCEPT_ALL_BIT];
  wire phys_ok = phys_node || phys_remote;

  // Final routing decision
  dest_t dest_nxt;
  always_comb begin
    dest_nxt = DEST_DROP;
    if (bypass) begin
      dest_nxt = DEST_PHYS;
    end else if (!async_ok) begin
      dest_nxt = DEST_DROP;
    end else if (in_phys && phys_ok) begin
      dest_nxt = DEST_PHYS;
    end else if (rrq_enable_r) begin
      dest_nxt = DEST_RRQ;
    end else begin
      dest_nxt = DEST_DROP;
    end
  end

  // Decision is registered: one cycle after the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid <= 1'b0;
      resp_ack <= 1'b0;
      resp_dest <= DEST_DROP;
    end else begin
      resp_valid <= req_valid;
      resp_ack <= req_valid && (dest_nxt != DEST_DROP);
      resp_dest <= req_valid ? dest_nxt : DEST_DROP;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_reject_async;
    @(posedge clk) disable iff (!rst_n)
      (req_valid && !bypass && !async_all && !async_node)
      |=> (!resp_ack && resp_dest == DEST_DROP);
  endproperty
  a_reject_async: assert property (p_reject_async)
    else $error("async-refused request was acknowledged");

  property p_bus_reset_async;
    @(posedge clk) disable iff (!rst_n)
      bus_reset |=> (async_lo_r == FILTER_RESET &&
                     async_hi_r[30:0] == 31'h0 &&
                     async_hi_r[ACCEPT_ALL_BIT] ==
                       $past(ahi_sw[ACCEPT_ALL_BIT]));
  endproperty
  a_bus_reset_async: assert property (p_bus_reset_async)
    else $error("bus reset mishandled async filter");

  property p_bus_reset_phys;
    @(posedge clk) disable iff (!rst_n)
      bus_reset |=> (phys_hi_r == FILTER_RESET &&
                     phys_lo_r == FILTER_RESET);
  endproperty
  a_bus_reset_phys: assert property (p_bus_reset_phys)
    else $error("bus reset left phys filter bits");

  property p_set_lo;
    @(posedge clk) disable iff (!rst_n)
      (hit_als && !bus_reset) |=> ((async_lo_r & $past(reg_wdata)) ==
                                   $past(reg_wdata));
  endproperty
  a_set_lo: assert property (p_set_lo)
    else $error("set write did not set async low bits");

  property p_clr_phys_lo;
    @(posedge clk) disable iff (!rst_n)
      hit_plc |=> ((phys_lo_r & $past(reg_wdata)) == 32'h0);
  endproperty
  a_clr_phys_lo: assert property (p_clr_phys_lo)
    else $error("clear write did not clear phys low bits");

  property p_read_back;
    @(posedge clk) disable iff (!rst_n)
      (reg_rd && reg_addr == OFF_PHYS_HI_CLR) |=>
        (reg_rdata == $past(phys_hi_r));
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("clear address read wrong contents");

  property p_above_limit;
    @(posedge clk) disable iff (!rst_n)
      (req_valid && !bypass && async_ok && !in_phys && rrq_enable_r)
      |=> (resp_dest == DEST_RRQ && resp_ack);
  endproperty
  a_above_limit: assert property (p_above_limit)
    else $error("above-limit request not sent to queue");

  property p_queue_off;
    @(posedge clk) disable iff (!rst_n)
      (req_valid && !bypass && !(in_phys && phys_ok) && !rrq_enable_r)
      |=> !resp_ack;
  endproperty
  a_queue_off: assert property (p_queue_off)
    else $error("request acked with queue disabled");

  property p_phys_route;
    @(posedge clk) disable iff (!rst_n)
      (req_valid && !bypass && async_ok && in_phys && phys_ok)
      |=> (resp_dest == DEST_PHYS);
  endproperty
  a_phys_route: assert property (p_phys_route)
    else $error("physical request not routed to physical unit");

  property p_refused_phys;
    @(posedge clk) disable iff (!rst_n)
      (req_valid && !bypass && async_ok && in_phys && !phys_ok)
      |=> (resp_dest == ($past(rrq_enable_r) ? DEST_RRQ : DEST_DROP));
  endproperty
  a_refused_phys: assert property (p_refused_phys)
    else $error("phys-refused request misrouted");

  property p_remote_phys;
    @(posedge clk) disable iff (!rst_n)
      (req_valid && !bypass && async_ok && in_phys && !bus_local &&
       phys_hi_r[ACCEPT_ALL_BIT]) |=> (resp_dest == DEST_PHYS);
  endproperty
  a_remote_phys: assert property (p_remote_phys)
    else $error("remote-bus physical request refused");

  property p_bypass_route;
    @(posedge clk) disable iff (!rst_n)
      (req_valid && bypass) |=> (resp_ack && resp_dest == DEST_PHYS);
  endproperty
  a_bypass_route: assert property (p_bypass_route)
    else $error("unfiltered area request not sent to physical unit");

  // With the queue on, accept-all leaves no request unacknowledged
  property p_accept_all;
    @(posedge clk) disable iff (!rst_n)
      (req_valid && async_hi_r[ACCEPT_ALL_BIT] && rrq_enable_r)
      |=> resp_ack;
  endproperty
  a_accept_all: assert property (p_accept_all)
    else $error("accept-all request was not acknowledged");

  property p_node_accept;
    @(posedge clk) disable iff (!rst_n)
      (req_valid && rrq_enable_r && !src_node[5] &&
       async_lo_r[src_node[4:0]] &&
       (src_bus == LOCAL_BUS || src_bus == local_bus_id)) |=> resp_ack;
  endproperty
  a_node_accept: assert property (p_node_accept)
    else $error("enabled local node was refused");

  property p_phys_node;
    @(posedge clk) disable iff (!rst_n)
      (req_valid && async_ok && in_phys && !src_node[5] &&
       phys_lo_r[src_node[4:0]] &&
       (src_bus == LOCAL_BUS || src_bus == local_bus_id))
      |=> (resp_dest == DEST_PHYS);
  endproperty
  a_phys_node: assert property (p_phys_node)
    else $error("enabled physical node not sent to physical unit");

  property p_range_edge;
    @(posedge clk) disable iff (!rst_n)
      (LIMIT_IMPL && req_valid && !bypass &&
       req_offset[47:16] >= limit_r) |=> (resp_dest != DEST_PHYS);
  endproperty
  a_range_edge: assert property (p_range_edge)
    else $error("request at or above limit reached physical unit");

  property p_fixed_range;
    @(posedge clk) disable iff (!rst_n)
      (!LIMIT_IMPL && req_valid && !bypass &&
       req_offset[47:32] != 16'h0000) |=> (resp_dest != DEST_PHYS);
  endproperty
  a_fixed_range: assert property (p_fixed_range)
    else $error("request beyond 4 GB reached physical unit");

  property p_read_async_lo;
    @(posedge clk) disable iff (!rst_n)
      (reg_rd && reg_addr == OFF_ASYNC_LO_SET) |=>
        (reg_rdata == $past(async_lo_r));
  endproperty
  a_read_async_lo: assert property (p_read_async_lo)
    else $error("set address read wrong contents");

  property p_set_hi;
    @(posedge clk) disable iff (!rst_n)
      (hit_ahs && !bus_reset) |=> ((async_hi_r & $past(reg_wdata)) ==
                                   $past(reg_wdata));
  endproperty
  a_set_hi: assert property (p_set_hi)
    else $error("set write did not set async high bits");

  property p_limit_write;
    @(posedge clk) disable iff (!rst_n)
      hit_lim |=> (limit_r ==
                   (LIMIT_IMPL ? $past(reg_wdata) : LIMIT_UNIMPL));
  endproperty
  a_limit_write: assert property (p_limit_write)
    else $error("limit write not stored as written");

  c_phys: cover property (@(posedge clk) resp_dest == DEST_PHYS);
  c_rrq: cover property (@(posedge clk) resp_dest == DEST_RRQ);
  c_drop: cover property (@(posedge clk) resp_valid && !resp_ack);
  c_breset: cover property (@(posedge clk) bus_reset && async_all);

endmodule : async_request_filter_router

// [verif/remote_node.sv]
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Remote serial bus node issuing requests
// ----------------------------------------------------------------
module remote_node (
  input wire logic clk,
  output logic req_valid,
  output logic [15:0] req_source_id,
  output logic [47:0] req_offset,
  output logic req_quadlet_read
);
  // Idle lines show the inverse of the last value, so no stale match
  initial begin
    req_valid = 1'b0;
    req_source_id = 16'h0000;
    req_offset = 48'h0;
    req_quadlet_read = 1'b0;
  end

  // One request lasts one cycle, launched just after a rising edge
  task automatic send(input logic [15:0] src, input logic [47:0] off);
    @(posedge clk);
    req_valid <= 1'b1;
    req_source_id <= src;
    req_offset <= off;
    req_quadlet_read <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    req_source_id <= ~src;
    req_offset <= ~off;
    req_quadlet_read <= 1'b0;
  endtask : send
endmodule : remote_node

// [verif/async_request_filter_router_bench.sv]
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Bench for the request filter and router
// ----------------------------------------------------------------
module async_request_filter_router_bench;
  import req_filter_pkg::*;
  typedef struct {
    logic [15:0] src;
    logic [47:0] off;
    dest_t d;
  } row_t;
  logic clk, rst_n, bus_reset, reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic req_valid, req_quadlet_read, resp_valid, resp_ack;
  logic [15:0] req_source_id;
  logic [47:0] req_offset;
  logic [9:0] local_bus_id;
  dest_t resp_dest;
  logic [31:0] fixed_rdata;
  logic fixed_valid, fixed_ack;
  dest_t fixed_dest;
  int n_errors = 0;
  int compares = 0;
  // Limit 1: physical range ends at 0x10000; async node 5,7,33; phys 5
  row_t rows [9] = '{
    '{{LOCAL_BUS, 6'h05}, 48'h100, DEST_PHYS},
    '{{10'h012, 6'h05}, 48'h0000_0000_FFFF, DEST_PHYS},
    '{{10'h012, 6'h05}, 48'h0000_0001_0000, DEST_RRQ},
    '{{LOCAL_BUS, 6'h07}, 48'h100, DEST_RRQ},
    '{{LOCAL_BUS, 6'h06}, 48'h100, DEST_DROP},
    '{{10'h001, 6'h05}, 48'h100, DEST_DROP},
    '{{LOCAL_BUS, 6'h21}, 48'h0, DEST_RRQ},
    '{{LOCAL_BUS, 6'h06}, ROM_BASE, DEST_PHYS},
    '{{LOCAL_BUS, 6'h06}, IRM_BASE, DEST_PHYS}
  };

  async_request_filter_router dut (
    .clk(clk), .rst_n(rst_n), .bus_reset(bus_reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
    .req_source_id(req_source_id), .req_offset(req_offset),
    .req_quadlet_read(req_quadlet_read), .local_bus_id(local_bus_id),
    .resp_valid(resp_valid), .resp_ack(resp_ack), .resp_dest(resp_dest)
  );

  remote_node node (
    .clk(clk), .req_valid(req_valid), .req_source_id(req_source_id),
    .req_offset(req_offset), .req_quadlet_read(req_quadlet_read)
  );

  // Variant without the limit register: range fixed at 4 GB
  async_request_filter_router #(.LIMIT_IMPL(1'b0)) dut_fixed (
    .clk(clk), .rst_n(rst_n), .bus_reset(bus_reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(fixed_rdata), .req_valid(req_valid),
    .req_source_id(req_source_id), .req_offset(req_offset),
    .req_quadlet_read(req_quadlet_read), .local_bus_id(local_bus_id),
    .resp_valid(fixed_valid), .resp_ack(fixed_ack), .resp_dest(fixed_dest)
  );

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic stop_test;
    if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk32

  // Response must stand exactly one cycle after the request edge
  task automatic chk_resp(input logic [3:0] g, input dest_t d);
    logic [3:0] e;
    e = {1'b1, d != DEST_DROP, d};
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_resp

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk32(reg_rdata, e);
  endtask : rd_chk

  task automatic req(input logic [15:0] s, input logic [47:0] o,
                     input dest_t d);
    node.send(s, o);
    #1 chk_resp({resp_valid, resp_ack, resp_dest}, d);
  endtask : req

  // Hard reset, held five cycles
  task automatic hard_reset;
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
  endtask : hard_reset

  // Hang guard: the whole sequence needs well under 5000 cycles
  initial begin
    #20000;
    n_errors++;
    stop_test();
  end

  initial begin
    rst_n = 1'b0;
    bus_reset = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    local_bus_id = 10'h012;
    hard_reset();
    // Every register, and the unmapped words after them, read zero
    for (int a = 0; a < 48; a += 4) rd_chk(a[7:0], 32'h0);
    wr(OFF_PHYS_LIMIT, 32'h0000_0001);
    wr(OFF_CTRL, 32'h0000_0001);
    wr(OFF_ASYNC_LO_SET, 32'h0000_00E0);
    wr(OFF_ASYNC_LO_CLR, 32'h0000_0040);
    wr(OFF_ASYNC_LO_CLR, 32'h0000_0000);
    rd_chk(OFF_ASYNC_LO_CLR, 32'h0000_00A0);
    rd_chk(OFF_ASYNC_LO_SET, 32'h0000_00A0);
    wr(OFF_PHYS_LO_SET, 32'h0000_0020);
    rd_chk(OFF_PHYS_LO_CLR, 32'h0000_0020);
    wr(OFF_ASYNC_HI_SET, 32'h0000_0002);
    rd_chk(OFF_ASYNC_HI_CLR, 32'h0000_0002);
    rd_chk(OFF_PHYS_LIMIT, 32'h0000_0001);
    chk32(fixed_rdata, 32'h0000_0000);
    // Routing table
    foreach (rows[i]) req(rows[i].src, rows[i].off, rows[i].d);
    // Fixed-range variant keeps the whole first 4 GB physical
    req({LOCAL_BUS, 6'h05}, 48'h0000_FFFF_FFFF, DEST_RRQ);
    chk_resp({fixed_valid, fixed_ack, fixed_dest}, DEST_PHYS);
    req({LOCAL_BUS, 6'h05}, 48'h0001_0000_0000, DEST_RRQ);
    chk_resp({fixed_valid, fixed_ack, fixed_dest}, DEST_RRQ);
    // Accept-all admits a remote bus; phys filter refuses it until the remote-bus bit is set
    wr(OFF_ASYNC_HI_SET, 32'h8000_0000);
    req({10'h001, 6'h09}, 48'h100, DEST_RRQ);
    wr(OFF_PHYS_HI_SET, 32'h8000_0000);
    req({10'h001, 6'h09}, 48'h100, DEST_PHYS);
    req({LOCAL_BUS, 6'h09}, 48'h100, DEST_RRQ);
    // Receive request queue disabled: queue-bound traffic vanishes
    wr(OFF_CTRL, 32'h0000_0000);
    req({LOCAL_BUS, 6'h07}, 48'h100, DEST_DROP);
    req({LOCAL_BUS, 6'h05}, 48'h0000_0002_0000, DEST_DROP);
    // Serial bus reset: node bits go, accept-all and limit stay
    @(posedge clk);
    bus_reset <= 1'b1;
    @(posedge clk);
    bus_reset <= 1'b0;
    rd_chk(OFF_ASYNC_HI_SET, 32'h8000_0000);
    rd_chk(OFF_ASYNC_LO_SET, 32'h0000_0000);
    rd_chk(OFF_PHYS_HI_CLR, 32'h0000_0000);
    rd_chk(OFF_PHYS_LO_SET, 32'h0000_0000);
    rd_chk(OFF_PHYS_LIMIT, 32'h0000_0001);
    wr(OFF_PHYS_LIMIT, LIMIT_MAX);
    rd_chk(OFF_PHYS_LIMIT, 32'hFFFF_0000);
    // Second hard reset clears the accept-all flag as well
    hard_reset();
    rd_chk(OFF_ASYNC_HI_SET, 32'h0000_0000);
    stop_test();
  end
endmodule : async_request_filter_router_bench
